// File: verilog/ubl_pkg.sv
// Functional notes
// RL1: divider value k 8..255, below 8 prohibited
// RL2: bit lasts two divider output periods
// RL3: software changes divider only with enables off
// RL4: divider register read/write, resets to FFH
// RL5: line control resets 16H, bit/byte writes
// RL6: bits 5..2 fixed 0101, bit 7 read-only
// RL7: break status set while receiving, cleared on good completion
// RL8: break error holds status, software re-triggers
// RL9: trigger reads 0, clears on good completion
// RL10: software triggers only with power and receive on
// RL11: writing 1 to trigger starts break reception
// RL12: tx invert bit selects transmit pin polarity
// RL13: bit order 0 MSB first, 1 LSB first
// RL14: capture input from pin or receive line
// RL15: external irq 0 from pin or receive line
// RL16: input switch resets 00H, bits 7..2 zero
// RL17: direction bit 0 output, 1 input, reset ones
// RL18: transmit use needs direction 0, latch 1
// RL19: receive use needs direction 1
// RL20: power off clears break status and trigger
// RL21: counter reloads every k ticks, toggles strobe
package ubl_pkg;
   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [15:0] ADDR_PORT1_DIR = 16'hff21;
   localparam logic [15:0] ADDR_INPUT_SW = 16'hff4f;
   localparam logic [15:0] ADDR_BAUD_DIV = 16'hff57;
   localparam logic [15:0] ADDR_LINE_CTRL = 16'hff58;
   localparam logic [7:0] RST_PORT1_DIR = 8'hff;
   localparam logic [7:0] RST_INPUT_SW = 8'h00;
   localparam logic [7:0] RST_BAUD_DIV = 8'hff;
   localparam logic [7:0] RST_LINE_CTRL = 8'h16;
   localparam logic [7:0] READ_IDLE = 8'h00;
   // ------------------------------------------------------------------
   // field layout
   // ------------------------------------------------------------------
   localparam int LC_STATUS_BIT = 7;
   localparam int LC_TRIG_BIT = 6;
   localparam int LC_ORDER_BIT = 1;
   localparam int LC_INV_BIT = 0;
   localparam logic [7:0] LC_FIXED_VAL = 8'h14;
   localparam logic [7:0] LC_WR_MASK = 8'h03;
   localparam int IS_CAP_BIT = 1;
   localparam int IS_IRQ_BIT = 0;
   localparam logic [7:0] IS_WR_MASK = 8'h03;
   localparam int TX_PIN_BIT = 3;
   localparam int RX_PIN_BIT = 4;
   localparam logic [7:0] DIV_MIN = 8'h08;
   localparam logic [7:0] DIV_START = 8'h01;
   // ------------------------------------------------------------------
   // break-field reception states
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      BRK_IDLE = 3'b001,
      BRK_WAIT = 3'b010,
      BRK_ERR = 3'b100
   } ubl_brk_t;

   // prohibited settings run as the fastest legal divisor would;
   // clamp to the least legal value so the counter never stalls
   function automatic logic [7:0] eff_div(input logic [7:0] k);
      eff_div = (k < DIV_MIN) ? DIV_MIN : k;
   endfunction
endpackage

// File: verilog/ubl_baud_div.sv
`timescale 1ns/1ps
module ubl_baud_div #(
   parameter int WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic run,
   input wire logic baseTick,
   input wire logic [WIDTH-1:0] divValue,
   output logic halfStrobe,
   output logic bitTick
);
   logic [WIDTH-1:0] cnt_reg;
   logic [WIDTH-1:0] effK;
   logic wrap;

   assign effK = ubl_pkg::eff_div(divValue); // [RL1]
   assign wrap = run && baseTick && (cnt_reg >= effK);

   // ------------------------------------------------------------------
   // counter and half-rate strobe
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= ubl_pkg::DIV_START;
      end else if (clkEn) begin
         if (!run) begin
            cnt_reg <= ubl_pkg::DIV_START;
         end else if (wrap) begin
            cnt_reg <= ubl_pkg::DIV_START; // [RL21]
         end else if (baseTick) begin
            cnt_reg <= cnt_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         halfStrobe <= 1'b0;
         bitTick <= 1'b0;
      end else if (clkEn) begin
         bitTick <= wrap && halfStrobe; // [RL2]
         if (!run) begin
            halfStrobe <= 1'b0;
         end else if (wrap) begin
            halfStrobe <= !halfStrobe; // [RL21]
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_div_toggle: assert property ( // [RL21]
      clkEn && wrap |=> halfStrobe != $past(halfStrobe))
      else $error("strobe did not toggle on reload");
   a_bit_every2: assert property ( // [RL2]
      bitTick |-> $past(halfStrobe) && !halfStrobe)
      else $error("bit tick outside second half period");
   a_cnt_bound: assert property ( // [RL1]
      run |-> cnt_reg <= effK)
      else $error("divider count beyond k");
endmodule

// File: verilog/ubl_pin_mux.sv
`timescale 1ns/1ps
module ubl_pin_mux (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic powerOn,
   input wire logic txEnable,
   input wire logic txPinDir,
   input wire logic rxPinDir,
   input wire logic txPinLatch,
   input wire logic rxPinLatch,
   input wire logic txInvert,
   input wire logic txSerial,
   input wire logic rxPinIn,
   input wire logic capturePinIn,
   input wire logic extIrqPinIn,
   input wire logic captureSrcSel,
   input wire logic extIrqSrcSel,
   output logic txPinOut,
   output logic txPinOe,
   output logic rxPinOut,
   output logic rxPinOe,
   output logic rxData,
   output logic timerCaptureIn,
   output logic extIrq0In
);
   logic txLine;

   // idle line is high; a stopped port must not leave the pin low
   assign txLine = (powerOn && txEnable) ? (txSerial ^ txInvert) : 1'b1;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         txPinOut <= 1'b1;
         txPinOe <= 1'b0;
         rxPinOut <= 1'b1;
         rxPinOe <= 1'b0;
      end else if (clkEn) begin
         // latch ANDs the serial line, hence latch must be 1 to transmit
         txPinOut <= txPinLatch & txLine; // [RL12] [RL18]
         txPinOe <= !txPinDir; // [RL17]
         rxPinOut <= rxPinLatch;
         rxPinOe <= !rxPinDir; // [RL17] [RL19]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rxData <= 1'b1;
         timerCaptureIn <= 1'b0;
         extIrq0In <= 1'b0;
      end else if (clkEn) begin
         rxData <= powerOn ? rxPinIn : 1'b1;
         timerCaptureIn <= captureSrcSel ? rxPinIn : capturePinIn; // [RL14]
         extIrq0In <= extIrqSrcSel ? rxPinIn : extIrqPinIn; // [RL15]
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_pin_oe: assert property ( // [RL17]
      clkEn |=> txPinOe == !$past(txPinDir) && rxPinOe == !$past(rxPinDir))
      else $error("pin enable not from direction bit");
   a_tx_polarity: assert property ( // [RL12]
      clkEn && powerOn && txEnable && txPinLatch
      |=> txPinOut == ($past(txSerial) ^ $past(txInvert)))
      else $error("transmit pin polarity wrong");
   a_cap_route: assert property ( // [RL14]
      clkEn && captureSrcSel |=> timerCaptureIn == $past(rxPinIn))
      else $error("capture not routed from receive pin");
endmodule

// File: verilog/ubl_line_ctrl.sv
`timescale 1ns/1ps
module ubl_line_ctrl #(
   parameter int DIV_WIDTH = 8
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regWrMask,
   input wire logic regWrStrobe,
   input wire logic regRdStrobe,
   output logic [7:0] regRdData,
   input wire logic serialPowerOn,
   input wire logic txEnable,
   input wire logic rxEnable,
   input wire logic baseClockTick,
   input wire logic breakFieldDone,
   input wire logic breakFieldError,
   input wire logic [7:0] port1Latch,
   input wire logic txSerial,
   input wire logic serialRxPin,
   input wire logic capturePin,
   input wire logic extIrqPin,
   output logic bitTick,
   output logic halfStrobe,
   output logic breakRxArm,
   output logic breakRxStatus,
   output logic bitOrderLsb,
   output logic txInvertOut,
   output logic serialTxPin,
   output logic serialTxPinOe,
   output logic rxPinOut,
   output logic rxPinOe,
   output logic serialRxData,
   output logic timerCaptureIn,
   output logic extIrq0In
);
   // ------------------------------------------------------------------
   // registers and decode
   // ------------------------------------------------------------------
   logic [7:0] port1Dir_reg;
   logic [7:0] inputSw_reg;
   logic [DIV_WIDTH-1:0] baudDiv_reg;
   logic [7:0] lineCtrl_reg;
   logic [7:0] readData_next;
   ubl_pkg::ubl_brk_t brkState_reg;
   ubl_pkg::ubl_brk_t brkState_next;
   logic hitDir;
   logic hitSw;
   logic hitDiv;
   logic hitLine;
   logic trigWrite;
   logic divRun;
   logic [7:0] lineView;
   logic [7:0] lineMask;
   logic [7:0] swMask;

   localparam logic RST_ORDER =
      ubl_pkg::RST_LINE_CTRL[ubl_pkg::LC_ORDER_BIT];
   localparam logic RST_INV =
      ubl_pkg::RST_LINE_CTRL[ubl_pkg::LC_INV_BIT];

   assign hitDir = regAddr == ubl_pkg::ADDR_PORT1_DIR;
   assign hitSw = regAddr == ubl_pkg::ADDR_INPUT_SW;
   assign hitDiv = regAddr == ubl_pkg::ADDR_BAUD_DIV;
   assign hitLine = regAddr == ubl_pkg::ADDR_LINE_CTRL;
   assign lineMask = regWrMask & ubl_pkg::LC_WR_MASK;
   assign swMask = regWrMask & ubl_pkg::IS_WR_MASK;

   // a rewrite of 1 restarts reception even if software meant a refresh
   assign trigWrite = regWrStrobe && hitLine &&
                      regWrMask[ubl_pkg::LC_TRIG_BIT] &&
                      regWrData[ubl_pkg::LC_TRIG_BIT]; // [RL11]

   // ------------------------------------------------------------------
   // writable registers
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         port1Dir_reg <= ubl_pkg::RST_PORT1_DIR; // [RL17]
      end else if (clkEn && regWrStrobe && hitDir) begin
         port1Dir_reg <= (port1Dir_reg & ~regWrMask) |
                         (regWrData & regWrMask); // [RL17]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         inputSw_reg <= ubl_pkg::RST_INPUT_SW; // [RL16]
      end else if (clkEn && regWrStrobe && hitSw) begin
         inputSw_reg <= (inputSw_reg & ~swMask) |
                        (regWrData & swMask); // [RL16]
      end
   end

   // no interlock with the enables: keeping them off is software's job
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         baudDiv_reg <= ubl_pkg::RST_BAUD_DIV; // [RL4]
      end else if (clkEn && regWrStrobe && hitDiv) begin
         baudDiv_reg <= (baudDiv_reg & ~regWrMask) |
                        (regWrData & regWrMask); // [RL4] [RL3]
      end
   end

   // only order and invert are stored; the rest is assembled on read
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         lineCtrl_reg <= ubl_pkg::RST_LINE_CTRL & ubl_pkg::LC_WR_MASK;
      end else if (clkEn && regWrStrobe && hitLine) begin
         lineCtrl_reg <= (lineCtrl_reg & ~lineMask) |
                         (regWrData & lineMask); // [RL5] [RL6]
      end
   end

   // ------------------------------------------------------------------
   // break-field reception control
   // ------------------------------------------------------------------
   always_comb begin
      brkState_next = brkState_reg;
      unique case (brkState_reg)
         ubl_pkg::BRK_IDLE: begin
            if (trigWrite) begin
               brkState_next = ubl_pkg::BRK_WAIT; // [RL11]
            end
         end
         ubl_pkg::BRK_WAIT: begin
            // a trigger in the completion cycle wins over the clear
            if (trigWrite) begin
               brkState_next = ubl_pkg::BRK_WAIT;
            end else if (breakFieldError) begin
               brkState_next = ubl_pkg::BRK_ERR; // [RL8]
            end else if (breakFieldDone) begin
               brkState_next = ubl_pkg::BRK_IDLE; // [RL7] [RL9]
            end
         end
         ubl_pkg::BRK_ERR: begin
            if (trigWrite) begin
               brkState_next = ubl_pkg::BRK_WAIT; // [RL8]
            end
         end
         default: begin
            brkState_next = ubl_pkg::BRK_IDLE;
         end
      endcase
      // power off resets the receive circuit regardless of state
      if (!serialPowerOn) begin
         brkState_next = ubl_pkg::BRK_IDLE; // [RL20] [RL7]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         brkState_reg <= ubl_pkg::BRK_IDLE;
      end else if (clkEn) begin
         brkState_reg <= brkState_next;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         breakRxArm <= 1'b0;
         breakRxStatus <= 1'b0;
      end else if (clkEn) begin
         breakRxArm <= brkState_next == ubl_pkg::BRK_WAIT; // [RL9]
         breakRxStatus <= brkState_next != ubl_pkg::BRK_IDLE; // [RL7]
      end
   end

   // ------------------------------------------------------------------
   // read path
   // ------------------------------------------------------------------
   always_comb begin
      lineView = ubl_pkg::LC_FIXED_VAL | lineCtrl_reg; // [RL6]
      lineView[ubl_pkg::LC_STATUS_BIT] = breakRxStatus; // [RL7]
      lineView[ubl_pkg::LC_TRIG_BIT] = 1'b0; // [RL9]
      readData_next = ubl_pkg::READ_IDLE;
      if (regRdStrobe) begin
         if (hitDir) begin
            readData_next = port1Dir_reg;
         end else if (hitSw) begin
            readData_next = inputSw_reg & ubl_pkg::IS_WR_MASK; // [RL16]
         end else if (hitDiv) begin
            readData_next = baudDiv_reg; // [RL4]
         end else if (hitLine) begin
            readData_next = lineView;
         end
      end
   end

   // data stand one cycle only; idle bus reads as zero
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= ubl_pkg::READ_IDLE;
      end else if (clkEn) begin
         regRdData <= readData_next;
      end
   end

   // ------------------------------------------------------------------
   // control outputs
   // ------------------------------------------------------------------
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         bitOrderLsb <= RST_ORDER;
         txInvertOut <= RST_INV;
      end else if (clkEn) begin
         bitOrderLsb <= lineCtrl_reg[ubl_pkg::LC_ORDER_BIT]; // [RL13]
         txInvertOut <= lineCtrl_reg[ubl_pkg::LC_INV_BIT]; // [RL12]
      end
   end

   // ------------------------------------------------------------------
   // baud divider and pin routing
   // ------------------------------------------------------------------
   assign divRun = serialPowerOn && (txEnable || rxEnable);

   ubl_baud_div #(
      .WIDTH(DIV_WIDTH)
   ) uDiv (
      .mclk(mclk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .run(divRun),
      .baseTick(baseClockTick),
      .divValue(baudDiv_reg),
      .halfStrobe(halfStrobe),
      .bitTick(bitTick)
   );

   ubl_pin_mux uPins (
      .mclk(mclk),
      .rst_n(rst_n),
      .clkEn(clkEn),
      .powerOn(serialPowerOn),
      .txEnable(txEnable),
      .txPinDir(port1Dir_reg[ubl_pkg::TX_PIN_BIT]),
      .rxPinDir(port1Dir_reg[ubl_pkg::RX_PIN_BIT]),
      .txPinLatch(port1Latch[ubl_pkg::TX_PIN_BIT]),
      .rxPinLatch(port1Latch[ubl_pkg::RX_PIN_BIT]),
      .txInvert(txInvertOut),
      .txSerial(txSerial),
      .rxPinIn(serialRxPin),
      .capturePinIn(capturePin),
      .extIrqPinIn(extIrqPin),
      .captureSrcSel(inputSw_reg[ubl_pkg::IS_CAP_BIT]),
      .extIrqSrcSel(inputSw_reg[ubl_pkg::IS_IRQ_BIT]),
      .txPinOut(serialTxPin),
      .txPinOe(serialTxPinOe),
      .rxPinOut(rxPinOut),
      .rxPinOe(rxPinOe),
      .rxData(serialRxData),
      .timerCaptureIn(timerCaptureIn),
      .extIrq0In(extIrq0In)
   );

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence s_trigger;
      clkEn && trigWrite && serialPowerOn;
   endsequence

   sequence s_good_end;
      clkEn && breakFieldDone && !breakFieldError && !trigWrite;
   endsequence

   a_trig_start: assert property ( // [RL11]
      s_trigger |=> breakRxStatus && breakRxArm)
      else $error("trigger did not start break reception");
   a_break_done: assert property ( // [RL7]
      breakRxArm ##0 s_good_end |=> !breakRxStatus && !breakRxArm)
      else $error("break status not cleared on completion");
   a_break_err: assert property ( // [RL8]
      breakRxArm && clkEn && breakFieldError && !trigWrite
      && serialPowerOn |=> breakRxStatus && !breakRxArm)
      else $error("break error did not hold status");
   a_power_clear: assert property ( // [RL20]
      clkEn && !serialPowerOn |=> !breakRxStatus && !breakRxArm)
      else $error("power off left break flags set");
   a_line_fixed: assert property ( // [RL6]
      clkEn && regRdStrobe && hitLine
      |=> regRdData[5:2] == 4'b0101 && regRdData[6] == 1'b0
          && regRdData[7] == $past(breakRxStatus))
      else $error("line control readback wrong");
   a_sw_upper: assert property ( // [RL16]
      clkEn && regRdStrobe && hitSw |=> regRdData[7:2] == 6'h00)
      else $error("input switch upper bits not zero");
   a_div_rdback: assert property ( // [RL4]
      clkEn && regWrStrobe && hitDiv && regWrMask == 8'hff
      ##1 clkEn && regRdStrobe && hitDiv |=> regRdData == $past(regWrData, 2))
      else $error("divider readback mismatch");
   a_read_once: assert property (
      clkEn && !regRdStrobe |=> regRdData == 8'h00)
      else $error("read data stood beyond one cycle");
endmodule

// File: tb/ubl_remote_node.sv
`timescale 1ns/1ps
module ubl_remote_node (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic sendBreak,
   input wire logic [7:0] breakLen,
   output logic rxLine
);
   logic [7:0] cntReg;
   // ---------------------------------------------------------------
   // break field generator
   // ---------------------------------------------------------------
   // line rests at the pulled-up mark level outside a break
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cntReg <= 8'h00;
      end else if (sendBreak) begin
         cntReg <= breakLen;
      end else if (cntReg != 8'h00) begin
         cntReg <= cntReg - 8'h01;
      end
   end
   assign rxLine = (cntReg == 8'h00);
endmodule

// File: tb/ubl_line_ctrl_tb.sv
`timescale 1ns/1ps
module ubl_line_ctrl_tb;
   logic mclk = 1'b0, rst_n = 1'b0, clkEn = 1'b1;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWrData = 8'h00, regWrMask = 8'h00, regRdData;
   logic regWrStrobe = 1'b0, regRdStrobe = 1'b0;
   logic serialPowerOn = 1'b0, txEnable = 1'b0, rxEnable = 1'b0;
   logic baseClockTick = 1'b1, breakFieldDone = 1'b0;
   logic breakFieldError = 1'b0, txSerial = 1'b0, capturePin = 1'b1;
   logic [7:0] port1Latch = 8'h08;
   logic extIrqPin = 1'b1, sendBreak = 1'b0, rxLine;
   logic bitTick, halfStrobe, breakRxArm, breakRxStatus, bitOrderLsb;
   logic txInvertOut, serialTxPin, serialTxPinOe, rxPinOut, rxPinOe;
   logic serialRxData, timerCaptureIn, extIrq0In;
   int error_cnt = 0, cmp_count = 0, cycCnt = 0, n;
   logic [7:0] kTab [3] = '{8'h08, 8'h03, 8'h09};
   logic [7:0] gapTab [3] = '{8'h10, 8'h10, 8'h12};

   ubl_line_ctrl dut (.mclk(mclk), .rst_n(rst_n), .clkEn(clkEn),
      .regAddr(regAddr), .regWrData(regWrData), .regWrMask(regWrMask),
      .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
      .regRdData(regRdData), .serialPowerOn(serialPowerOn),
      .txEnable(txEnable), .rxEnable(rxEnable),
      .baseClockTick(baseClockTick), .breakFieldDone(breakFieldDone),
      .breakFieldError(breakFieldError), .port1Latch(port1Latch),
      .txSerial(txSerial), .serialRxPin(rxLine), .capturePin(capturePin),
      .extIrqPin(extIrqPin), .bitTick(bitTick), .halfStrobe(halfStrobe),
      .breakRxArm(breakRxArm), .breakRxStatus(breakRxStatus),
      .bitOrderLsb(bitOrderLsb), .txInvertOut(txInvertOut),
      .serialTxPin(serialTxPin), .serialTxPinOe(serialTxPinOe),
      .rxPinOut(rxPinOut), .rxPinOe(rxPinOe), .serialRxData(serialRxData),
      .timerCaptureIn(timerCaptureIn), .extIrq0In(extIrq0In));

   ubl_remote_node node (.mclk(mclk), .rst_n(rst_n), .sendBreak(sendBreak),
      .breakLen(8'h28), .rxLine(rxLine));

   always #25 mclk = ~mclk;
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic finish_test;
      $display("errors=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // a hung wait must not stall the run forever
   always @(posedge mclk) begin
      cycCnt <= cycCnt + 1;
      if (cycCnt == 20000) begin
         error_cnt++;
         finish_test;
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int c);
      repeat (c) @(posedge mclk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d,
                     input logic [7:0] m);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWrMask <= m;
      regWrStrobe <= 1'b1;
      @(posedge mclk);
      regWrStrobe <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      @(posedge mclk);
      regAddr <= a;
      regRdStrobe <= 1'b1;
      @(posedge mclk);
      regRdStrobe <= 1'b0;
      #1 check(regRdData, exp);
   endtask
   task automatic chk_brk(input logic stat, input logic arm);
      check({6'h00, breakRxStatus, breakRxArm}, {6'h00, stat, arm});
   endtask
   task automatic brk_evt(input logic err);
      @(posedge mclk);
      breakFieldError <= err;
      breakFieldDone <= !err;
      @(posedge mclk);
      breakFieldError <= 1'b0;
      breakFieldDone <= 1'b0;
      cyc(1);
   endtask
   task automatic wait_tick(output int c);
      c = 0;
      do begin
         @(posedge mclk);
         #1 c++;
      end while (bitTick !== 1'b1 && c < 1200);
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic test_reset;
      rd_chk(ubl_pkg::ADDR_PORT1_DIR, 8'hff);
      rd_chk(ubl_pkg::ADDR_INPUT_SW, 8'h00);
      rd_chk(ubl_pkg::ADDR_BAUD_DIV, 8'hff);
      rd_chk(ubl_pkg::ADDR_LINE_CTRL, 8'h16);
      rd_chk(16'hff00, 8'h00);
   endtask
   task automatic test_regs;
      // power is off, so the trigger bit must not arm here
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'hff, 8'hff);
      rd_chk(ubl_pkg::ADDR_LINE_CTRL, 8'h17);
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h00, 8'h01);
      rd_chk(ubl_pkg::ADDR_LINE_CTRL, 8'h16);
      check({7'h00, bitOrderLsb}, 8'h01);
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h00, 8'h02);
      cyc(2);
      check({7'h00, bitOrderLsb}, 8'h00);
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h16, 8'hff);
      wr(ubl_pkg::ADDR_INPUT_SW, 8'hff, 8'hff);
      rd_chk(ubl_pkg::ADDR_INPUT_SW, 8'h03);
      @(posedge mclk);
      regAddr <= ubl_pkg::ADDR_BAUD_DIV;
      regWrData <= 8'h5a;
      regWrMask <= 8'hff;
      regWrStrobe <= 1'b1;
      // read straight behind the write, no idle cycle between
      @(posedge mclk);
      regWrStrobe <= 1'b0;
      regRdStrobe <= 1'b1;
      @(posedge mclk);
      regRdStrobe <= 1'b0;
      #1 check(regRdData, 8'h5a);
      // a write while the clock enable is low must not land
      @(posedge mclk);
      clkEn <= 1'b0;
      wr(ubl_pkg::ADDR_BAUD_DIV, 8'h33, 8'hff);
      clkEn <= 1'b1;
      rd_chk(ubl_pkg::ADDR_BAUD_DIV, 8'h5a);
   endtask
   task automatic test_divider;
      for (int i = 0; i < 3; i++) begin
         wr(ubl_pkg::ADDR_BAUD_DIV, kTab[i], 8'hff);
         serialPowerOn <= 1'b1;
         txEnable <= 1'b1;
         wait_tick(n);
         wait_tick(n);
         check(n[7:0], gapTab[i]);
         check({7'h00, halfStrobe}, 8'h00);
         @(posedge mclk);
         txEnable <= 1'b0;
      end
   endtask
   task automatic test_break;
      rxEnable <= 1'b1;
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h40, 8'h40);
      cyc(1);
      chk_brk(1'b1, 1'b1);
      rd_chk(ubl_pkg::ADDR_LINE_CTRL, 8'h96);
      brk_evt(1'b0);
      chk_brk(1'b0, 1'b0);
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h40, 8'h40);
      brk_evt(1'b1);
      chk_brk(1'b1, 1'b0);
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h40, 8'h40);
      cyc(1);
      chk_brk(1'b1, 1'b1);
      @(posedge mclk);
      serialPowerOn <= 1'b0;
      cyc(2);
      chk_brk(1'b0, 1'b0);
      @(posedge mclk);
      rxEnable <= 1'b0;
   endtask
   task automatic test_pins;
      wr(ubl_pkg::ADDR_PORT1_DIR, 8'hf7, 8'hff);
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h00, 8'h01);
      serialPowerOn <= 1'b1;
      txEnable <= 1'b1;
      rxEnable <= 1'b1;
      cyc(4);
      check({7'h00, serialTxPin}, 8'h00);
      check({6'h00, serialTxPinOe, rxPinOe}, 8'h02);
      check({6'h00, serialRxData, rxPinOut}, 8'h02);
      @(posedge mclk);
      txEnable <= 1'b0;
      rxEnable <= 1'b0;
      wr(ubl_pkg::ADDR_LINE_CTRL, 8'h01, 8'h01);
      txEnable <= 1'b1;
      rxEnable <= 1'b1;
      cyc(4);
      check({7'h00, serialTxPin}, 8'h01);
      wr(ubl_pkg::ADDR_INPUT_SW, 8'h03, 8'hff);
      @(posedge mclk);
      sendBreak <= 1'b1;
      @(posedge mclk);
      sendBreak <= 1'b0;
      cyc(3);
      check({7'h00, timerCaptureIn}, 8'h00);
      check({7'h00, extIrq0In}, 8'h00);
      check({6'h00, serialRxData, rxPinOut}, 8'h00);
      wr(ubl_pkg::ADDR_INPUT_SW, 8'h00, 8'hff);
      cyc(3);
      check({7'h00, timerCaptureIn}, 8'h01);
      check({7'h00, extIrq0In}, 8'h01);
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (10) @(posedge mclk);
      rst_n <= 1'b1;
      test_reset();
      test_regs();
      test_divider();
      test_break();
      test_pins();
      cyc(2);
      finish_test();
   end
endmodule
